// [bench/osc_model.sv]
// Oscillator model: ring, main and sub tones for the clock control block.
// Assumes each enable is high while the matching oscillator should run.
`timescale 1ns/1ps

module osc_model (
	input wire logic ring_en,
	input wire logic main_en,
	input wire logic sub_en,
	output logic ring_out,
	output logic main_out,
	output logic sub_out
);
	logic r_ff = 1'b0;
	logic m_ff = 1'b0;
	logic s_ff = 1'b0;
	// Tones start 1 ns off the clk grid; main stands for an RC network, not an external clock.
	initial begin
		#1;
		fork
			forever #20 r_ff = ~r_ff;
			forever #10 m_ff = ~m_ff;
			forever #80 s_ff = ~s_ff;
		join
	end
	// A stopped oscillator rests low.
	assign ring_out = ring_en & r_ff;
	assign main_out = main_en & m_ff;
	assign sub_out = sub_en & s_ff;
endmodule

// [bench/system_clock_control_tb_top.sv]
// Testbench for the system clock control block: bus tasks, tick spacing, enables, RC select.
// Assumes osc_model drives the sources with periods of 8, 4 and 32 clk cycles.
`timescale 1ns/1ps

module system_clock_control_tb_top;
	import clk_ctrl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] be = 4'hF;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, q;
	logic wait_q, sys_clk, tick, r_en, m_en, cer, rc, s_en, pins, r_o, m_o, s_o;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'hc4c2_0fe1;
	logic [3:0] m;
	logic [3:0] v;
	logic [3:0] tbl [7] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1, 4'h2, 4'h7};

	always #2.5 clk = ~clk;

	system_clock_control i_system_clock_control (.clk(clk), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd),
		.avs_readdata(rdata), .avs_waitrequest(wait_q), .ring_osc_clock(r_o),
		.primary_osc_clock(m_o), .secondary_osc_clock(s_o), .sys_clk(sys_clk),
		.instr_tick(tick), .ring_osc_en(r_en), .main_osc_en(m_en), .main_ceramic_en(cer),
		.main_rc_en(rc), .sub_osc_en(s_en), .port_pins_sel(pins));
	osc_model i_osc_model (.ring_en(r_en), .main_en(m_en), .sub_en(s_en), .ring_out(r_o),
		.main_out(m_o), .sub_out(s_o));

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: %s got %h exp %h", $time, s, g, e);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is seen low, however long.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wait_q !== 1'b0) begin
			@(posedge clk);
			k++;
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
		chk(32'(k), 32'h1, "bus answer");
	endtask

	// Measures the spacing of instruction ticks after the source has settled.
	task automatic span(input int e);
		int c;
		for (int i = 0; i < 3; i++) begin
			c = 0;
			@(posedge clk);
			while (tick !== 1'b1 && c < 600) begin
				@(posedge clk);
				c++;
			end
		end
		chk({31'h0, sys_clk}, 32'h1, "clock at tick");
		chk(c + 1, e, "tick spacing");
	endtask

	function automatic int per(input logic [3:0] md);
		return (md[1:0] == 2'h1 ? 4 : (md[1:0] == 2'h2 ? 32 : 8)) << md[3:2];
	endfunction

	// Reset state, then an unmapped write and a masked write that must change nothing.
	task automatic after_reset();
		chk({26'h0, r_en, m_en, s_en, cer, rc, pins}, 32'h3C, "reset outputs");
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({24'h0, q[7:1], 1'b0}, 32'h0, "reset status");
		bus(1'b1, 4'h2, 32'h3);
		be <= 4'h0;
		bus(1'b1, OFS_CLOCK_MODE, 32'h1);
		be <= 4'hF;
		bus(1'b0, OFS_CLOCK_MODE, 32'h0);
		chk(q, 32'hC, "reset mode");
		span(64);
		m = MODE_RESET;
		$display("Test reset done");
	endtask

	task automatic finish_test();
		$display("Counts: checked %0d, bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		after_reset();
		// Fixed corners, then random modes; code 11 keeps the old source.
		for (int i = 0; i < 13; i++) begin
			v = (i < 7) ? tbl[i] : 4'($random(seed));
			bus(1'b1, OFS_CLOCK_MODE, {28'h0, v});
			m[3:2] = v[3:2];
			if (v[1:0] != SRC_NONE) m[1:0] = v[1:0];
			bus(1'b0, OFS_CLOCK_MODE, 32'h0);
			chk(q, {28'h0, m}, "mode readback");
			span(per(m));
		end
		$display("Test modes done");
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, OFS_OSC_CTRL, 32'(i));
			@(posedge clk);
			chk({29'h0, s_en, m_en, r_en}, 32'(~i & 7), "osc enables");
			chk({31'h0, pins}, 32'(i >> 2), "port pins");
			bus(1'b0, OFS_STATUS, 32'h0);
			chk({29'h0, q[5:3]}, 32'(i), "stop bits");
		end
		bus(1'b0, OFS_OSC_CTRL, 32'h0);
		chk(q, 32'h0, "osc ctrl write only");
		bus(1'b1, OFS_OSC_CTRL, 32'h0);
		$display("Test oscillators done");
		repeat (2) begin
			bus(1'b1, OFS_RC_SELECT, $random(seed));
			@(posedge clk);
			chk({30'h0, cer, rc}, 32'h1, "rc mode");
		end
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({30'h0, q[7:6]}, 32'h3, "rc status");
		$display("Test rc done");
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		after_reset();
		finish_test();
	end
endmodule

// [hw/clk_ctrl_pkg.sv]
// Constants for the system clock control block: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
//
// Functional notes
// - After reset the system clock runs from the ring oscillator.
// - Main oscillator starts in ceramic mode with RC mode off.
// - RC-select disables ceramic operation and enables RC oscillation.
// - RC-select acts once after reset; the choice holds until reset.
// - Oscillator-control bit 2 set stops sub-oscillator and gives pins to port.
// - Clock-mode register sets the system clock; load writes it from accumulator.
// - Read-clock-mode copies the clock-mode register into the accumulator.
// - Oscillator-control register starts or stops each oscillator; written by load.
// - System and instruction clocks come through a multiplexer then a divider.
// - Mode bits 3:2 select through, /2, /4, /8; reset value 1100.
// - Mode bits 1:0 pick ring, main or sub source; code 11 never used.
// - Control bit 1 stops main, bit 0 stops ring; all reset to zero.
package clk_ctrl_pkg;
	localparam logic [3:0] OFS_CLOCK_MODE = 4'h0;
	localparam logic [3:0] OFS_OSC_CTRL = 4'h4;
	localparam logic [3:0] OFS_RC_SELECT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	localparam int MODE_SRC_LSB = 0;
	localparam int MODE_DIV_LSB = 2;
	localparam int OSC_RING_STOP_BIT = 0;
	localparam int OSC_MAIN_STOP_BIT = 1;
	localparam int OSC_SUB_STOP_BIT = 2;
	localparam logic [3:0] MODE_RESET = 4'hC;
	localparam logic [2:0] OSC_CTRL_RESET = 3'h0;
	localparam logic [1:0] SRC_RING = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_SUB = 2'h2;
	localparam logic [1:0] SRC_NONE = 2'h3;
	localparam logic [1:0] DIV_THROUGH = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_4 = 2'h2;
	localparam logic [1:0] DIV_BY_8 = 2'h3;
	typedef enum logic [1:0] {REG_MODE, REG_OSC, REG_RC, REG_STATUS} reg_sel_t;
endpackage

// [hw/system_clock_control.sv]
// System clock control: source multiplexer, divider, oscillator start/stop and RC select.
// Assumes oscillator outputs arrive as asynchronous levels that are slow next to clk,
// and that a 32-bit Avalon-MM master stands in for the accumulator transfer instructions.
`timescale 1ns/1ps

module system_clock_control
	import clk_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ring_osc_clock,
	input wire logic primary_osc_clock,
	input wire logic secondary_osc_clock,
	output logic sys_clk,
	output logic instr_tick,
	output logic ring_osc_en,
	output logic main_osc_en,
	output logic main_ceramic_en,
	output logic main_rc_en,
	output logic sub_osc_en,
	output logic port_pins_sel
);

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] src_prev;
		logic [2:0] div_cnt;
		logic [3:0] mode;
		logic [2:0] osc_stop;
		logic rc_mode;
		logic rc_done;
		logic sys_clk;
		logic instr_tick;
		logic wait_req;
		logic [31:0] rdata;
		logic [1:0] cur_src;
		logic [2:0] osc_run;
		logic ceramic;
		logic mode_seen;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// Maps a byte address onto a register, or reports it unmapped.
	function automatic logic decode_hit(input logic [3:0] addr, output reg_sel_t sel);
		decode_hit = 1'b1;
		sel = REG_STATUS;
		case (addr)
			OFS_CLOCK_MODE: sel = REG_MODE;
			OFS_OSC_CTRL: sel = REG_OSC;
			OFS_RC_SELECT: sel = REG_RC;
			OFS_STATUS: sel = REG_STATUS;
			default: decode_hit = 1'b0;
		endcase
	endfunction

	// Picks the synchronised level of the chosen source, gated by its stop bit.
	function automatic logic pick_source(input logic [1:0] src, input logic [2:0] lvl,
		input logic [2:0] stop);
		case (src)
			SRC_RING: pick_source = lvl[0] & ~stop[OSC_RING_STOP_BIT];
			SRC_MAIN: pick_source = lvl[1] & ~stop[OSC_MAIN_STOP_BIT];
			SRC_SUB: pick_source = lvl[2] & ~stop[OSC_SUB_STOP_BIT];
			default: pick_source = 1'b0;
		endcase
	endfunction

	logic wr_acc;
	logic rd_req;
	logic wr_hit;
	logic rd_hit;
	reg_sel_t wr_sel;
	reg_sel_t rd_sel;
	logic src_lvl;
	logic src_rise;
	logic div_lvl;

	// The write takes effect at the edge where waitrequest is seen low.
	always_comb begin
		wr_acc = avs_write & ~st_ff.wait_req & avs_byteenable[0];
		rd_req = avs_read & st_ff.wait_req;
		wr_hit = decode_hit(avs_address, wr_sel);
		rd_hit = decode_hit(avs_address, rd_sel);
	end

	// Source multiplexer, then the divider taps the edge counter.
	always_comb begin
		src_lvl = pick_source(st_ff.cur_src, st_ff.sync2, st_ff.osc_stop);
		src_rise = src_lvl & ~st_ff.src_prev[0];
		case (st_ff.mode[MODE_DIV_LSB +: 2])
			DIV_THROUGH: div_lvl = src_lvl;
			DIV_BY_2: div_lvl = st_ff.div_cnt[0];
			DIV_BY_4: div_lvl = st_ff.div_cnt[1];
			DIV_BY_8: div_lvl = st_ff.div_cnt[2];
			default: div_lvl = 1'b0;
		endcase
	end

	// Next-state logic for the whole block.
	always_comb begin
		nxt_st = st_ff;
		// Two flip-flops on each oscillator before anything looks at it.
		nxt_st.sync1 = {secondary_osc_clock, primary_osc_clock, ring_osc_clock};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.src_prev = {2'b00, src_lvl};
		if (src_rise) begin
			nxt_st.div_cnt = st_ff.div_cnt + 3'd1;
		end
		nxt_st.sys_clk = div_lvl;
		nxt_st.instr_tick = div_lvl & ~st_ff.sys_clk;
		// The source changes on a rising divided edge, or while the source level and the system clock are both low.
		if (div_lvl & ~st_ff.sys_clk) begin
			nxt_st.cur_src = st_ff.mode[MODE_SRC_LSB +: 2];
		end
		if (st_ff.mode[MODE_SRC_LSB +: 2] != st_ff.cur_src && ~src_lvl && ~st_ff.sys_clk) begin
			nxt_st.cur_src = st_ff.mode[MODE_SRC_LSB +: 2];
		end

		// One wait cycle per access, then one cycle of waitrequest low.
		nxt_st.wait_req = ~((avs_read | avs_write) & st_ff.wait_req);
		if (rd_req) begin
			nxt_st.rdata = 32'h0000_0000;
			if (rd_hit) begin
				case (rd_sel)
					REG_MODE: nxt_st.rdata[3:0] = st_ff.mode;
					REG_STATUS: nxt_st.rdata[7:0] = {st_ff.rc_done, st_ff.rc_mode,
						st_ff.osc_stop, st_ff.cur_src, st_ff.sys_clk};
					default: nxt_st.rdata = 32'h0000_0000;
				endcase
			end
		end

		if (wr_acc && wr_hit) begin
			case (wr_sel)
				REG_MODE: begin
					nxt_st.mode_seen = 1'b1;
					nxt_st.mode[MODE_DIV_LSB +: 2] = avs_writedata[MODE_DIV_LSB +: 2];
					// Code 11 is refused; the source stays as it was.
					if (avs_writedata[MODE_SRC_LSB +: 2] != SRC_NONE) begin
						nxt_st.mode[MODE_SRC_LSB +: 2] = avs_writedata[MODE_SRC_LSB +: 2];
					end
				end
				REG_OSC: nxt_st.osc_stop = avs_writedata[2:0];
				REG_RC: begin
					// Only the first select after reset counts.
					if (!st_ff.rc_done) begin
						nxt_st.rc_mode = 1'b1;
						nxt_st.rc_done = 1'b1;
					end
				end
				default: nxt_st.rc_done = st_ff.rc_done;
			endcase
		end
		// Enable copies are registered so that every output leaves straight from a flop.
		nxt_st.osc_run = ~nxt_st.osc_stop;
		nxt_st.ceramic = ~nxt_st.rc_mode;
	end

	// Registers the record; reset puts the block on the ring oscillator.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff.sync1 <= 3'h0;
			st_ff.sync2 <= 3'h0;
			st_ff.src_prev <= 3'h0;
			st_ff.div_cnt <= 3'h0;
			st_ff.mode <= MODE_RESET;
			st_ff.osc_stop <= OSC_CTRL_RESET;
			st_ff.rc_mode <= 1'b0;
			st_ff.rc_done <= 1'b0;
			st_ff.sys_clk <= 1'b0;
			st_ff.instr_tick <= 1'b0;
			st_ff.wait_req <= 1'b1;
			st_ff.rdata <= 32'h0000_0000;
			st_ff.cur_src <= SRC_RING;
			st_ff.osc_run <= ~OSC_CTRL_RESET;
			st_ff.ceramic <= 1'b1;
			st_ff.mode_seen <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs come straight from the record.
	assign avs_readdata = st_ff.rdata;
	assign avs_waitrequest = st_ff.wait_req;
	assign sys_clk = st_ff.sys_clk;
	assign instr_tick = st_ff.instr_tick;
	assign ring_osc_en = st_ff.osc_run[OSC_RING_STOP_BIT];
	assign main_osc_en = st_ff.osc_run[OSC_MAIN_STOP_BIT];
	assign main_ceramic_en = st_ff.ceramic;
	assign main_rc_en = st_ff.rc_mode;
	assign sub_osc_en = st_ff.osc_run[OSC_SUB_STOP_BIT];
	assign port_pins_sel = st_ff.osc_stop[OSC_SUB_STOP_BIT];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_reset_ring_src: assert property (!st_ff.mode_seen |-> st_ff.cur_src == SRC_RING)
		else $error("Source left the ring oscillator before any mode write.");

	a_ceramic_at_start: assert property (!st_ff.rc_done |-> main_ceramic_en && !main_rc_en)
		else $error("Main oscillator is not in ceramic mode before RC select.");

	a_rc_select_acts: assert property (
		wr_acc && wr_hit && wr_sel == REG_RC |=> main_rc_en && !main_ceramic_en)
		else $error("RC select did not switch the main oscillator to RC mode.");

	a_rc_choice_holds: assert property (st_ff.rc_done |=> st_ff.rc_done && $stable(main_rc_en))
		else $error("RC choice changed after it was made.");

	a_port_pins_take: assert property (
		wr_acc && wr_hit && wr_sel == REG_OSC |=>
		port_pins_sel == $past(avs_writedata[2]) && sub_osc_en == !$past(avs_writedata[2]))
		else $error("Sub-oscillator stop bit did not hand the pins to the port.");

	a_mode_load: assert property (
		wr_acc && wr_hit && wr_sel == REG_MODE |=>
		st_ff.mode[3:2] == $past(avs_writedata[3:2]))
		else $error("Division field did not take the written value.");

	a_mode_readback: assert property (
		avs_read && !avs_waitrequest && avs_address == OFS_CLOCK_MODE |->
		avs_readdata == {28'h000_0000, st_ff.mode})
		else $error("Mode read returned a value other than the mode register.");

	a_osc_stop_bits: assert property (
		wr_acc && wr_hit && wr_sel == REG_OSC |=>
		ring_osc_en == !$past(avs_writedata[0]) && main_osc_en == !$past(avs_writedata[1]))
		else $error("Ring or main stop bit did not reach its enable.");

	a_no_code_three: assert property (st_ff.mode[1:0] != SRC_NONE ##0 st_ff.cur_src != SRC_NONE)
		else $error("Source code 11 reached the clock mode register.");

	a_tick_spacing: assert property (instr_tick |=> !instr_tick)
		else $error("Instruction tick lasted more than one cycle.");

	a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Waitrequest stayed low for more than one cycle.");

	a_wait_answers: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("A taken request was not answered in the next cycle.");

	a_osc_read_zero: assert property (
		avs_read && avs_waitrequest && avs_address == OFS_OSC_CTRL |=>
		avs_readdata == 32'h0000_0000)
		else $error("The write-only oscillator control register read back non-zero.");

	a_status_stop_bits: assert property (
		avs_read && avs_waitrequest && avs_address == OFS_STATUS |=>
		avs_readdata[5:3] == st_ff.osc_stop && avs_readdata[31:8] == 24'h00_0000)
		else $error("Status read did not show the oscillator stop bits.");

	a_code_three_kept: assert property (
		wr_acc && wr_hit && wr_sel == REG_MODE && avs_writedata[1:0] == SRC_NONE |=>
		st_ff.mode[1:0] == $past(st_ff.mode[1:0]))
		else $error("Source code 11 replaced the selected source.");

	a_src_takes_write: assert property (
		wr_acc && wr_hit && wr_sel == REG_MODE && avs_writedata[1:0] != SRC_NONE |=>
		st_ff.mode[1:0] == $past(avs_writedata[1:0]))
		else $error("Source field did not take the written value.");

	a_masked_write_ignored: assert property (
		avs_write && !avs_waitrequest && !avs_byteenable[0] |=>
		$stable(st_ff.mode) && $stable(st_ff.osc_stop) && $stable(st_ff.rc_done))
		else $error("A write with lane 0 masked changed a register.");

	a_rc_second_ignored: assert property (
		wr_acc && wr_hit && wr_sel == REG_RC && st_ff.rc_done |=> $stable(st_ff.rc_mode))
		else $error("A second RC select changed the main oscillator mode.");

	a_tick_with_clock: assert property (instr_tick |-> sys_clk)
		else $error("Instruction tick came while the system clock was low.");

	a_tick_on_rise: assert property (instr_tick == $rose(st_ff.sys_clk))
		else $error("Instruction tick did not match a system clock rise.");

	a_enables_follow_stop: assert property (
		ring_osc_en != st_ff.osc_stop[OSC_RING_STOP_BIT] &&
		main_osc_en != st_ff.osc_stop[OSC_MAIN_STOP_BIT] &&
		sub_osc_en != st_ff.osc_stop[OSC_SUB_STOP_BIT])
		else $error("An oscillator enable disagrees with its stop bit.");

	a_pins_track_sub: assert property (port_pins_sel != sub_osc_en)
		else $error("Port pins and sub-oscillator were both active or both idle.");

	a_main_mode_exclusive: assert property (main_ceramic_en != main_rc_en)
		else $error("Ceramic and RC operation were enabled together or neither.");

	a_stopped_src_quiet: assert property (
		(st_ff.cur_src == SRC_RING && st_ff.osc_stop[OSC_RING_STOP_BIT]) ||
		(st_ff.cur_src == SRC_MAIN && st_ff.osc_stop[OSC_MAIN_STOP_BIT]) ||
		(st_ff.cur_src == SRC_SUB && st_ff.osc_stop[OSC_SUB_STOP_BIT]) |-> !src_lvl)
		else $error("A stopped source still reached the divider.");

	a_src_change_legal: assert property (
		$changed(st_ff.cur_src) |-> st_ff.cur_src == $past(st_ff.mode[MODE_SRC_LSB +: 2]))
		else $error("The running source changed to a value other than the mode field.");

	a_divider_counts: assert property (
		src_rise |=> st_ff.div_cnt == $past(st_ff.div_cnt) + 3'd1)
		else $error("Divider did not count a source rising edge.");

	a_through_follows_src: assert property (
		st_ff.mode[MODE_DIV_LSB +: 2] == DIV_THROUGH |=> st_ff.sys_clk == $past(src_lvl))
		else $error("Through mode did not pass the source level to the system clock.");

endmodule
